// >>> common/iefc_pkg.sv
// constants shared by the interrupt enable and flag control block
package iefc_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [5:0] IEFC_OFF_CTRL   = 6'h00;
    localparam logic [5:0] IEFC_OFF_PFLAG1 = 6'h04;
    localparam logic [5:0] IEFC_OFF_PFLAG2 = 6'h08;
    localparam logic [5:0] IEFC_OFF_PEN1   = 6'h0C;
    localparam logic [5:0] IEFC_OFF_PEN2   = 6'h10;
    localparam logic [5:0] IEFC_OFF_PPRI1  = 6'h14;
    localparam logic [5:0] IEFC_OFF_PPRI2  = 6'h18;
    localparam logic [5:0] IEFC_OFF_CFG    = 6'h1C;
    localparam logic [5:0] IEFC_OFF_PORT   = 6'h20;

    // ************************************************************
    // interrupt_control bit positions
    // ************************************************************
    localparam int IEFC_B_GHE   = 7;
    localparam int IEFC_B_PLE   = 6;
    localparam int IEFC_B_TOIE  = 5;
    localparam int IEFC_B_EPIE  = 4;
    localparam int IEFC_B_PCIE  = 3;
    localparam int IEFC_B_TOF   = 2;
    localparam int IEFC_B_EPF   = 1;
    localparam int IEFC_B_PCF   = 0;

    // ************************************************************
    // peripheral_flag_one bit positions
    // ************************************************************
    localparam int IEFC_B_PPF   = 7;
    localparam int IEFC_B_ADF   = 6;
    localparam int IEFC_B_SRXF  = 5;
    localparam int IEFC_B_STXF  = 4;
    localparam int IEFC_B_SSPF  = 3;
    localparam int IEFC_B_CCPF  = 2;
    localparam int IEFC_B_T2F   = 1;
    localparam int IEFC_B_T1F   = 0;
    // software may write all but the two serial buffer flags
    localparam logic [7:0] IEFC_PFLAG1_WMASK = 8'hCF;

    // ************************************************************
    // configuration bit positions
    // ************************************************************
    localparam int IEFC_B_PMS   = 0;
    localparam int IEFC_B_TOPRI = 1;
    localparam int IEFC_B_PCPRI = 2;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] IEFC_RST_CTRL = 8'h00;
    localparam logic [7:0] IEFC_RST_FLAG = 8'h00;
    localparam logic [7:0] IEFC_RST_EN   = 8'h00;
    localparam logic [7:0] IEFC_RST_PRI  = 8'hFF;
    localparam logic [2:0] IEFC_RST_CFG  = 3'h6;

    // ************************************************************
    // bus responses
    // ************************************************************
    localparam logic [1:0] IEFC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] IEFC_RESP_SLVERR = 2'h2;

endpackage

// >>> hw/iefc_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module iefc_sync
    import iefc_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } iefc_sync_t;

    iefc_sync_t st;
    iefc_sync_t next_st;

    // ************************************************************
    // per-bit stages; stage1 feeds stage2 only
    // ************************************************************
    always_comb begin
        next_st = st;
        for (int i = 0; i < WIDTH; i++) begin
            next_st.stage1[i] = async_in[i];
            next_st.stage2[i] = st.stage1[i];
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;

endmodule

`default_nettype wire

// >>> hw/iefc_ctrl.sv
// interrupt enable and flag control with an axi4-lite register slave
//
// Summary of operation
// - flags latch events regardless of enables
// - compat mode: high enable gates every interrupt
// - priority mode: high enable gates high-priority only
// - compat mode: low enable gates peripheral interrupts
// - priority mode: low enable gates low-priority peripherals
// - timer overflow enable gates its request
// - external pin enable gates its request
// - port change enable gates its request
// - timer overflow flag sticky until software clears
// - external pin flag sticky until software clears
// - upper port pin change sets port flag
// - mismatch keeps flag set until port read
// - peripheral flags split over two registers
// - parallel port access sets flag, software clears
// - serial flags follow buffer full and empty
// - other peripheral flags set by event or by a software write of one
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module iefc_ctrl
    import iefc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // axi4-lite slave
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pins
    input  wire logic        ext_pin,
    input  wire logic [3:0]  upper_port_pins,
    // same-clock event sources
    input  wire logic        timer_zero_overflow,
    input  wire logic        parallel_port_access,
    input  wire logic        adc_done,
    input  wire logic        serial_rx_full,
    input  wire logic        serial_tx_empty,
    input  wire logic        ssp_done,
    input  wire logic        capture_compare_event,
    input  wire logic        timer_two_match,
    input  wire logic        timer_one_overflow,
    input  wire logic [7:0]  periph_two_events,
    // requests to the core
    output logic             irq_high,
    output logic             irq_low
);

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  pflag1;
        logic [7:0]  pflag2;
        logic [7:0]  pen1;
        logic [7:0]  pen2;
        logic [7:0]  ppri1;
        logic [7:0]  ppri2;
        logic [2:0]  cfg;
        logic [3:0]  port_latch;
        logic        ext_prev;
        logic        aw_held;
        logic [5:0]  aw_addr;
        logic        w_held;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        irq_high;
        logic        irq_low;
    } iefc_state_t;

    iefc_state_t st;
    iefc_state_t next_st;

    logic [4:0] pins_sync;
    logic       ext_sync;
    logic [3:0] port_sync;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    iefc_sync #(
        .WIDTH (5)
    ) u_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .ce       (ce),
        .async_in ({ext_pin, upper_port_pins}),
        .sync_out (pins_sync)
    );

    assign ext_sync  = pins_sync[4];
    assign port_sync = pins_sync[3:0];

    // ************************************************************
    // combinational helpers
    // ************************************************************
    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    logic       do_write;
    logic       ext_event;
    logic       mismatch;
    logic [7:0] pf1_set;
    logic [7:0] pf1_wr;
    logic [7:0] ctrl_set;
    logic [7:0] ctrl_wr;
    logic       pms;
    logic       ghe;
    logic       ple;
    logic       to_req;
    logic       ep_req;
    logic       pc_req;
    logic [7:0] p1_req;
    logic [7:0] p2_req;
    logic       core_hi;
    logic       core_lo;
    logic       per_hi;
    logic       per_lo;
    logic       any_per;
    logic       any_core;

    // bus handshakes; one write and one read outstanding at most
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready  = !st.w_held && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign aw_hs         = s_axi_awvalid && s_axi_awready;
    assign w_hs          = s_axi_wvalid && s_axi_wready;
    assign ar_hs         = s_axi_arvalid && s_axi_arready;
    assign do_write      = st.aw_held && st.w_held && !st.bvalid && st.w_lane0;

    // rising edge on the synchronised external pin
    assign ext_event = ext_sync && !st.ext_prev;

    // port change persists while pins differ from the last port read
    assign mismatch = (port_sync != st.port_latch);

    // hardware set terms of interrupt_control
    always_comb begin
        ctrl_set              = '0;
        ctrl_set[IEFC_B_TOF]  = timer_zero_overflow;
        ctrl_set[IEFC_B_EPF]  = ext_event;
        ctrl_set[IEFC_B_PCF]  = mismatch;
    end

    // hardware set terms of peripheral_flag_one
    always_comb begin
        pf1_set              = '0;
        pf1_set[IEFC_B_PPF]  = parallel_port_access;
        pf1_set[IEFC_B_ADF]  = adc_done;
        pf1_set[IEFC_B_SSPF] = ssp_done;
        pf1_set[IEFC_B_CCPF] = capture_compare_event;
        pf1_set[IEFC_B_T2F]  = timer_two_match;
        pf1_set[IEFC_B_T1F]  = timer_one_overflow;
    end

    // software-written values, held where no write lands
    assign ctrl_wr = (do_write && st.aw_addr == IEFC_OFF_CTRL) ? st.w_data : st.ctrl;
    assign pf1_wr  = (do_write && st.aw_addr == IEFC_OFF_PFLAG1) ? st.w_data : st.pflag1;

    // ************************************************************
    // request gating toward the core
    // ************************************************************
    assign pms    = st.cfg[IEFC_B_PMS];
    assign ghe    = st.ctrl[IEFC_B_GHE];
    assign ple    = st.ctrl[IEFC_B_PLE];
    assign to_req = st.ctrl[IEFC_B_TOIE] && st.ctrl[IEFC_B_TOF];
    assign ep_req = st.ctrl[IEFC_B_EPIE] && st.ctrl[IEFC_B_EPF];
    assign pc_req = st.ctrl[IEFC_B_PCIE] && st.ctrl[IEFC_B_PCF];
    assign p1_req = st.pflag1 & st.pen1;
    assign p2_req = st.pflag2 & st.pen2;

    // the external pin source is always high priority
    assign core_hi  = ep_req || (to_req && st.cfg[IEFC_B_TOPRI])
                      || (pc_req && st.cfg[IEFC_B_PCPRI]);
    assign core_lo  = (to_req && !st.cfg[IEFC_B_TOPRI])
                      || (pc_req && !st.cfg[IEFC_B_PCPRI]);
    assign per_hi   = |(p1_req & st.ppri1) || |(p2_req & st.ppri2);
    assign per_lo   = |(p1_req & ~st.ppri1) || |(p2_req & ~st.ppri2);
    assign any_per  = |p1_req || |p2_req;
    assign any_core = to_req || ep_req || pc_req;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;

        // write address and data may arrive in either order
        if (aw_hs) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            next_st.w_held  = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end

        // complete the write once both halves are held
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = IEFC_RESP_OKAY;
            if (st.aw_addr[1:0] != 2'h0 || st.aw_addr > IEFC_OFF_PORT) begin
                next_st.bresp = IEFC_RESP_SLVERR;
            end
            if (st.w_lane0) begin
                unique case (st.aw_addr)
                    IEFC_OFF_PFLAG2: next_st.pflag2 = st.w_data;
                    IEFC_OFF_PEN1:   next_st.pen1 = st.w_data;
                    IEFC_OFF_PEN2:   next_st.pen2 = st.w_data;
                    IEFC_OFF_PPRI1:  next_st.ppri1 = st.w_data;
                    IEFC_OFF_PPRI2:  next_st.ppri2 = st.w_data;
                    IEFC_OFF_CFG:    next_st.cfg = st.w_data[2:0];
                    default:         next_st.cfg = st.cfg;
                endcase
            end
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // flags: an event in the clearing cycle wins over the clear
        next_st.ctrl = ctrl_wr | ctrl_set;
        next_st.pflag1 = ((pf1_wr | pf1_set) & IEFC_PFLAG1_WMASK)
                         | {2'h0, serial_rx_full, serial_tx_empty, 4'h0};
        next_st.pflag2 = next_st.pflag2 | periph_two_events;

        // read channel; a port read ends the mismatch
        if (ar_hs) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = IEFC_RESP_OKAY;
            next_st.rdata  = '0;
            unique case (s_axi_araddr)
                IEFC_OFF_CTRL:   next_st.rdata[7:0] = st.ctrl;
                IEFC_OFF_PFLAG1: next_st.rdata[7:0] = st.pflag1;
                IEFC_OFF_PFLAG2: next_st.rdata[7:0] = st.pflag2;
                IEFC_OFF_PEN1:   next_st.rdata[7:0] = st.pen1;
                IEFC_OFF_PEN2:   next_st.rdata[7:0] = st.pen2;
                IEFC_OFF_PPRI1:  next_st.rdata[7:0] = st.ppri1;
                IEFC_OFF_PPRI2:  next_st.rdata[7:0] = st.ppri2;
                IEFC_OFF_CFG:    next_st.rdata[2:0] = st.cfg;
                IEFC_OFF_PORT: begin
                    next_st.rdata[3:0] = port_sync;
                    next_st.port_latch = port_sync;
                end
                default: next_st.rresp = IEFC_RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        next_st.ext_prev = ext_sync;

        // requests: flag, its enable and the global enables together
        if (pms) begin
            next_st.irq_high = ghe && (core_hi || per_hi);
            next_st.irq_low  = ple && (core_lo || per_lo);
        end else begin
            next_st.irq_high = ghe && (any_core || (ple && any_per));
            next_st.irq_low  = 1'b0;
        end
    end

    // ************************************************************
    // state register, frozen while ce is low
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st        <= '0;
            st.ctrl   <= IEFC_RST_CTRL;
            st.pflag1 <= IEFC_RST_FLAG;
            st.pflag2 <= IEFC_RST_FLAG;
            st.pen1   <= IEFC_RST_EN;
            st.pen2   <= IEFC_RST_EN;
            st.ppri1  <= IEFC_RST_PRI;
            st.ppri2  <= IEFC_RST_PRI;
            st.cfg    <= IEFC_RST_CFG;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // registered outputs
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp  = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata  = st.rdata;
    assign s_axi_rresp  = st.rresp;
    assign irq_high     = st.irq_high;
    assign irq_low      = st.irq_low;

endmodule

`default_nettype wire

// >>> testbench/iefc_src_model.sv
// peripheral event source model driving the flag inputs
`timescale 1ns/1ps
`default_nettype none

module iefc_src_model
    import iefc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [6:0] kick,
    output logic            timer_zero_overflow,
    output logic            parallel_port_access,
    output logic            adc_done,
    output logic            ssp_done,
    output logic            capture_compare_event,
    output logic            timer_two_match,
    output logic            timer_one_overflow
);
    logic [6:0] pulse = 7'h00;

    // one clean pulse per kick, never stretched, so each event is counted once
    always @(posedge sys_clk) begin
        pulse <= kick;
    end

    assign timer_zero_overflow   = pulse[0];
    assign parallel_port_access  = pulse[1];
    assign adc_done              = pulse[2];
    assign ssp_done              = pulse[3];
    assign capture_compare_event = pulse[4];
    assign timer_two_match       = pulse[5];
    assign timer_one_overflow    = pulse[6];
endmodule
`default_nettype wire

// >>> testbench/iefc_ctrl_assertions.sv
// concurrent checks on the register bus and request outputs
`timescale 1ns/1ps
`default_nettype none

module iefc_ctrl_chk
    import iefc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        irq_high,
    input  wire logic        irq_low
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // ************************************************************
    // bus and request checks
    // ************************************************************
    logic wr_go;
    // both write halves taken at one edge
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped early");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped early");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_lat_a: assert property (wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two edges after accept");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    bad_wr_a: assert property (wr_go && s_axi_awaddr > IEFC_OFF_PORT |-> ##2
        s_axi_bresp == IEFC_RESP_SLVERR) else $error("unmapped write not refused");
    bad_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > IEFC_OFF_PORT
        |=> s_axi_rresp == IEFC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rd_high_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    rst_irq_a: assert property ($rose(nrst) |-> !irq_high && !irq_low)
        else $error("request raised out of reset");
endmodule

bind iefc_ctrl iefc_ctrl_chk iefc_ctrl_chk_i (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_high, .irq_low);
`default_nettype wire

// >>> testbench/tb_interrupt_enable_flag_control.sv
// self-checking bench for the interrupt enable and flag control block
`timescale 1ns/1ps
`default_nettype none

module tb_interrupt_enable_flag_control;
    import iefc_pkg::*;
    logic        sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1;
    logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    // response readies stay high, so back-to-back calls never retoggle them in one step
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        ext_pin = 1'b0, serial_rx_full = 1'b0, serial_tx_empty = 1'b0;
    logic [3:0]  upper_port_pins = 4'h0;
    logic [7:0]  periph_two_events = 8'h00, e;
    logic [6:0]  kick = 7'h00;
    logic        timer_zero_overflow, parallel_port_access, adc_done, ssp_done;
    logic        capture_compare_event, timer_two_match, timer_one_overflow, irq_high, irq_low;
    logic [31:0] v;
    logic [1:0]  r;
    int          n_fail = 0, samples_checked = 0;
    logic [7:0]  rst_v [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h06, 8'h00};
    logic [7:0]  pf_bit [7] = '{8'h00, 8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01};

    always #5 sys_clk = ~sys_clk;

    iefc_ctrl iefc_ctrl_i (.sys_clk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_pin, .upper_port_pins,
        .timer_zero_overflow, .parallel_port_access, .adc_done, .serial_rx_full,
        .serial_tx_empty, .ssp_done, .capture_compare_event, .timer_two_match,
        .timer_one_overflow, .periph_two_events, .irq_high, .irq_low);
    iefc_src_model iefc_src_model_i (.sys_clk, .kick, .timer_zero_overflow,
        .parallel_port_access, .adc_done, .ssp_done, .capture_compare_event,
        .timer_two_match, .timer_one_overflow);

    // ************************************************************
    // bus tasks and comparisons
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // both halves offered together, each released at its own accept edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (pa || pw) begin
            @(posedge sys_clk);
            if (pa && s_axi_awready) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [5:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        r = s_axi_rresp;
        v = s_axi_rdata;
    endtask
    task automatic wok(input logic [5:0] a, input logic [7:0] d);
        wr(a, d);
        chk("bresp", {30'h0, IEFC_RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] x);
        rd(a);
        chk("rresp", {30'h0, IEFC_RESP_OKAY}, {30'h0, r});
        chk("rdata", {24'h0, x}, v);
    endtask
    // request outputs settle one cycle behind the register state
    task automatic ichk(input logic hi, input logic lo);
        cyc(2);
        chk("irq_high", {31'h0, hi}, {31'h0, irq_high});
        chk("irq_low", {31'h0, lo}, {31'h0, irq_low});
    endtask
    task automatic fire(input logic [6:0] m);
        kick <= m;
        @(posedge sys_clk);
        kick <= 7'h00;
        cyc(3);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        cyc(5000);
        n_fail++;
        test_done();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        cyc(6);
        nrst <= 1'b1;
        cyc(1);
        for (int i = 0; i < 9; i++) rchk(6'(4 * i), rst_v[i]);
        fire(7'h01);
        rchk(IEFC_OFF_CTRL, 8'h04);
        wok(IEFC_OFF_CTRL, 8'h84);
        ichk(1'b0, 1'b0);
        wok(IEFC_OFF_CTRL, 8'hA4);
        ichk(1'b1, 1'b0);
        cyc(20);
        rchk(IEFC_OFF_CTRL, 8'hA4);
        wok(IEFC_OFF_CTRL, 8'h24);
        ichk(1'b0, 1'b0);
        wok(IEFC_OFF_CTRL, 8'h00);
        rchk(IEFC_OFF_CTRL, 8'h00);
        ext_pin <= 1'b1;
        cyc(6);
        ext_pin <= 1'b0;
        cyc(6);
        rchk(IEFC_OFF_CTRL, 8'h02);
        wok(IEFC_OFF_CTRL, 8'h92);
        ichk(1'b1, 1'b0);
        wok(IEFC_OFF_CTRL, 8'h00);
        upper_port_pins <= 4'h5;
        cyc(6);
        rchk(IEFC_OFF_CTRL, 8'h01);
        wok(IEFC_OFF_CTRL, 8'h00);
        rchk(IEFC_OFF_CTRL, 8'h01);
        rd(IEFC_OFF_PORT);
        cyc(2);
        wok(IEFC_OFF_CTRL, 8'h00);
        rchk(IEFC_OFF_CTRL, 8'h00);
        wok(IEFC_OFF_CTRL, 8'h89);
        ichk(1'b1, 1'b0);
        wok(IEFC_OFF_CTRL, 8'h00);
        e = 8'h00;
        for (int i = 1; i < 7; i++) begin
            fire(7'(1 << i));
            e = e | pf_bit[i];
            rchk(IEFC_OFF_PFLAG1, e);
        end
        wok(IEFC_OFF_PFLAG1, 8'h00);
        rchk(IEFC_OFF_PFLAG1, 8'h00);
        periph_two_events <= 8'hA5;
        cyc(1);
        periph_two_events <= 8'h00;
        cyc(2);
        rchk(IEFC_OFF_PFLAG2, 8'hA5);
        wok(IEFC_OFF_PFLAG2, 8'h00);
        serial_rx_full <= 1'b1;
        cyc(3);
        // a one written to the idle transmit flag must not stick
        wok(IEFC_OFF_PFLAG1, 8'h10);
        rchk(IEFC_OFF_PFLAG1, 8'h20);
        serial_rx_full <= 1'b0;
        serial_tx_empty <= 1'b1;
        cyc(3);
        rchk(IEFC_OFF_PFLAG1, 8'h10);
        serial_tx_empty <= 1'b0;
        fire(7'h04);
        wok(IEFC_OFF_PEN1, 8'h40);
        wok(IEFC_OFF_CTRL, 8'h80);
        ichk(1'b0, 1'b0);
        wok(IEFC_OFF_CTRL, 8'hC0);
        ichk(1'b1, 1'b0);
        wok(IEFC_OFF_CFG, 8'h07);
        wok(IEFC_OFF_PPRI1, 8'hBF);
        ichk(1'b0, 1'b1);
        wok(IEFC_OFF_CTRL, 8'h80);
        ichk(1'b0, 1'b0);
        wok(IEFC_OFF_PPRI1, 8'hFF);
        ichk(1'b1, 1'b0);
        wok(IEFC_OFF_CTRL, 8'h40);
        ichk(1'b0, 1'b0);
        // an overflow pulse while the clock enable is low is not seen
        ce <= 1'b0;
        fire(7'h01);
        ce <= 1'b1;
        rchk(IEFC_OFF_CTRL, 8'h40);
        wr(6'h24, 8'h01);
        chk("bad bresp", {30'h0, IEFC_RESP_SLVERR}, {30'h0, r});
        rd(6'h24);
        chk("bad rresp", {30'h0, IEFC_RESP_SLVERR}, {30'h0, r});
        chk("bad rdata", 32'h0, v);
        test_done();
    end
endmodule
`default_nettype wire
